// ==== design/adr_regs.sv ====
// accelerometer readout register bank with avalon-mm slave
//
// The Avalon-MM register port was chosen for this implementation.
module adr_regs (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // sample input from the conversion logic
  input wire logic [11:0] x_sample_in,
  input wire logic x_sample_valid_in,
  // avalon-mm slave
  input wire logic [adr_pkg::ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [adr_pkg::DATA_W-1:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [adr_pkg::DATA_W-1:0] readdata_out,
  output logic waitrequest_out,
  output logic [1:0] response_out,
  // status
  output logic deep_suspend_out,
  output logic soft_reset_pulse_out
);
  import adr_pkg::*;

  typedef struct packed {
    logic [11:0] x_live;
    logic [7:0] x_high_shadow;
    logic locked;
    logic new_data;
    logic x_stale;
    logic [7:0] range;
    logic [7:0] bw;
    logic [7:0] pwr;
    logic [7:0] lpcfg;
    logic [7:0] dpcfg;
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] en_c;
    logic [USER_N-1:0][7:0] user;
    logic done;
    logic wait_req;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic srst;
  } adr_state_t;

  adr_state_t st_reg;
  adr_state_t st_next;

  // word index of a byte address
  function automatic logic [7:0] adr_idx(input logic [7:0] a);
    adr_idx = {2'h0, a[7:2]};
  endfunction

  function automatic logic [7:0] adr_wr8(input logic [7:0] old,
                                         input logic [31:0] d,
                                         input logic be);
    adr_wr8 = be ? d[7:0] : old;
  endfunction

  logic req;
  logic [7:0] idx;
  logic [7:0] rbyte;
  logic hit;
  logic [7:0] x_low;
  logic [7:0] x_high;

  always_comb begin
    req = (read_in || write_in) && !st_reg.done;
    idx = adr_idx(address_in);
    x_low = {st_reg.x_live[3:0], UNDEF_BITS, 1'b0, st_reg.new_data};
    x_high = st_reg.locked ? st_reg.x_high_shadow
                           : st_reg.x_live[11:X_HIGH_LSB];
    hit = 1'b1;
    rbyte = RST_ZERO;
    case (idx)
      OFF_IDENT: rbyte = IDENT_VALUE;
      OFF_X_LOW: rbyte = x_low;
      OFF_X_HIGH: rbyte = x_high;
      OFF_Y_LOW, OFF_Y_HIGH, OFF_Z_LOW, OFF_Z_HIGH, OFF_TEMP,
      OFF_EVT_A, OFF_EVT_B, OFF_MOTION, OFF_ORIENT, OFF_QUEUE,
      OFF_SWRST: rbyte = RST_ZERO;
      OFF_RSVD_0D, OFF_RSVD_15: rbyte = RSVD_VALUE;
      OFF_RANGE: rbyte = st_reg.range;
      OFF_BW: rbyte = st_reg.bw;
      OFF_PWR: rbyte = st_reg.pwr;
      OFF_LPCFG: rbyte = st_reg.lpcfg;
      OFF_DPCFG: rbyte = st_reg.dpcfg;
      OFF_EN_A: rbyte = st_reg.en_a;
      OFF_EN_B: rbyte = st_reg.en_b;
      OFF_EN_C: rbyte = st_reg.en_c;
      OFF_USER0: rbyte = st_reg.user[0];
      OFF_USER1: rbyte = st_reg.user[1];
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.srst = 1'b0;
    st_next.done = 1'b0;
    if (x_sample_valid_in) begin
      st_next.x_live = x_sample_in;
    end
    if (req) begin
      st_next.done = 1'b1;
      st_next.resp = hit ? 2'h0 : 2'h2;
      st_next.rdata = read_in ? {24'h0, rbyte} : 32'h0;
      if (read_in && idx == OFF_X_LOW) begin
        if (!st_reg.dpcfg[SHADOW_DIS_BIT]) begin
          st_next.locked = 1'b1;
          st_next.x_high_shadow = st_reg.x_live[11:X_HIGH_LSB];
          st_next.x_stale = 1'b0;
        end
        if (st_reg.dpcfg[SHADOW_DIS_BIT]) begin
          st_next.new_data = 1'b0;
        end
      end
      if (read_in && idx == OFF_X_HIGH) begin
        st_next.locked = 1'b0;
        // a sample that landed behind the lock is still unread
        if (!st_reg.x_stale) begin
          st_next.new_data = 1'b0;
        end
        st_next.x_stale = 1'b0;
      end
      if (write_in) begin
        case (idx)
          OFF_RANGE: st_next.range = adr_wr8(st_reg.range, writedata_in,
                                             byteenable_in[0]);
          OFF_BW: st_next.bw = adr_wr8(st_reg.bw, writedata_in,
                                       byteenable_in[0]);
          OFF_PWR: st_next.pwr = adr_wr8(st_reg.pwr, writedata_in,
                                         byteenable_in[0]);
          OFF_LPCFG: st_next.lpcfg = adr_wr8(st_reg.lpcfg, writedata_in,
                                             byteenable_in[0]);
          OFF_DPCFG: st_next.dpcfg = adr_wr8(st_reg.dpcfg, writedata_in,
                                             byteenable_in[0]);
          OFF_EN_A: st_next.en_a = adr_wr8(st_reg.en_a, writedata_in,
                                           byteenable_in[0]);
          OFF_EN_B: st_next.en_b = adr_wr8(st_reg.en_b, writedata_in,
                                           byteenable_in[0]);
          OFF_EN_C: st_next.en_c = adr_wr8(st_reg.en_c, writedata_in,
                                           byteenable_in[0]);
          OFF_USER0: st_next.user[0] = adr_wr8(st_reg.user[0],
                                               writedata_in,
                                               byteenable_in[0]);
          OFF_USER1: st_next.user[1] = adr_wr8(st_reg.user[1],
                                               writedata_in,
                                               byteenable_in[0]);
          OFF_SWRST: st_next.srst = byteenable_in[0] &&
                                    writedata_in[7:0] == SWRST_CODE;
          default: st_next.done = 1'b1;
        endcase
      end
    end
    // soft reset restores shared config; scratch and live sample kept
    if (st_reg.srst) begin
      st_next.range = RST_RANGE;
      st_next.bw = RST_BW;
      st_next.pwr = RST_ZERO;
      st_next.lpcfg = RST_ZERO;
      st_next.dpcfg = RST_ZERO;
      st_next.en_a = RST_ZERO;
      st_next.en_b = RST_ZERO;
      st_next.en_c = RST_ZERO;
      st_next.locked = 1'b0;
      st_next.x_stale = 1'b0;
    end
    // sample arriving while locked is not the one the host reads
    if (x_sample_valid_in && st_next.locked) begin
      st_next.x_stale = 1'b1;
    end
    // fresh sample sets the flag; set wins over a same-cycle clear
    if (x_sample_valid_in) begin
      st_next.new_data = 1'b1;
    end
    st_next.wait_req = !st_next.done;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_reg <= '0;
      st_reg.range <= RST_RANGE;
      st_reg.bw <= RST_BW;
      st_reg.wait_req <= 1'b1;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    readdata_out = st_reg.rdata;
    waitrequest_out = st_reg.wait_req;
    response_out = st_reg.resp;
    deep_suspend_out = st_reg.pwr[DEEP_SUSPEND_BIT];
    soft_reset_pulse_out = st_reg.srst;
  end
endmodule

// ==== design/adr_pkg.sv ====
// constants for the accelerometer readout register bank
package adr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_IDENT = 8'h00;
  localparam logic [7:0] OFF_X_LOW = 8'h02;
  localparam logic [7:0] OFF_X_HIGH = 8'h03;
  localparam logic [7:0] OFF_Y_LOW = 8'h04;
  localparam logic [7:0] OFF_Y_HIGH = 8'h05;
  localparam logic [7:0] OFF_Z_LOW = 8'h06;
  localparam logic [7:0] OFF_Z_HIGH = 8'h07;
  localparam logic [7:0] OFF_TEMP = 8'h08;
  localparam logic [7:0] OFF_EVT_A = 8'h09;
  localparam logic [7:0] OFF_EVT_B = 8'h0A;
  localparam logic [7:0] OFF_MOTION = 8'h0B;
  localparam logic [7:0] OFF_ORIENT = 8'h0C;
  localparam logic [7:0] OFF_RSVD_0D = 8'h0D;
  localparam logic [7:0] OFF_QUEUE = 8'h0E;
  localparam logic [7:0] OFF_RANGE = 8'h0F;
  localparam logic [7:0] OFF_BW = 8'h10;
  localparam logic [7:0] OFF_PWR = 8'h11;
  localparam logic [7:0] OFF_LPCFG = 8'h12;
  localparam logic [7:0] OFF_DPCFG = 8'h13;
  localparam logic [7:0] OFF_SWRST = 8'h14;
  localparam logic [7:0] OFF_RSVD_15 = 8'h15;
  localparam logic [7:0] OFF_EN_A = 8'h16;
  localparam logic [7:0] OFF_EN_B = 8'h17;
  localparam logic [7:0] OFF_EN_C = 8'h18;
  localparam logic [7:0] OFF_USER0 = 8'h1C;
  localparam logic [7:0] OFF_USER1 = 8'h1D;
  localparam int USER_N = 2;
  // arbitrary neutral identification value
  localparam logic [7:0] IDENT_VALUE = 8'h5A;
  localparam logic [7:0] RST_RANGE = 8'h03;
  localparam logic [7:0] RST_BW = 8'h0F;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RSVD_VALUE = 8'hFF;
  localparam logic [7:0] SWRST_CODE = 8'hB6;
  localparam int SHADOW_DIS_BIT = 6;
  localparam int DEEP_SUSPEND_BIT = 5;
  localparam int X_HIGH_LSB = 4;
  localparam logic [1:0] UNDEF_BITS = 2'h0;
endpackage

// ==== tb/adr_regs_assertions.sv ====
// checker for the readout register bank, bound to its top
module adr_regs_assertions
  import adr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // sample side and bus
  input wire logic [11:0] x_sample_in,
  input wire logic x_sample_valid_in,
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [DATA_W-1:0] writedata_in,
  input wire logic [DATA_W-1:0] readdata_out,
  input wire logic waitrequest_out
);
  logic tr, tw, lo, nd, lk, ps, sd, srw, rl, rh;
  logic [11:0] xs;
  logic [7:0] hv, sc;
  assign tr = read_in && waitrequest_out;
  assign tw = write_in && waitrequest_out;
  assign rl = tr && address_in == 8'h08;
  assign rh = tr && address_in == 8'h0C;
  assign lo = rl && !x_sample_valid_in;
  assign srw = tw && address_in == 8'h50 && writedata_in[7:0] == SWRST_CODE;
  // reference sample, flag, lock, pending sample, shadow-off and scratch
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      {nd, lk, ps, sd, xs, hv, sc} <= '0;
    end else begin
      if (x_sample_valid_in) xs <= x_sample_in;
      nd <= x_sample_valid_in | (nd & ~(rh && !ps) & ~(rl && sd));
      if (rl) hv <= xs[11:4];
      if (rl && !sd) lk <= 1'b1;
      else if (rh || srw) lk <= 1'b0;
      if (rh || srw) ps <= 1'b0;
      else if (rl && !sd) ps <= x_sample_valid_in;
      else if (x_sample_valid_in && lk) ps <= 1'b1;
      if (tw && address_in == 8'h4C) sd <= writedata_in[SHADOW_DIS_BIT];
      else if (srw) sd <= 1'b0;
      if (tw && address_in == 8'h70) sc <= writedata_in[7:0];
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_id;
    tr && address_in == 8'h00 |=> readdata_out[7:0] == IDENT_VALUE;
  endproperty
  a_id: assert property (p_id) else $error("id");
  property p_b1;
    tr && address_in == 8'h08 |=> !readdata_out[1];
  endproperty
  a_b1: assert property (p_b1) else $error("bit1");
  property p_lo;
    lo |=> readdata_out[7:4] == xs[3:0];
  endproperty
  a_lo: assert property (p_lo) else $error("low");
  property p_nd;
    lo |=> readdata_out[0] == $past(nd);
  endproperty
  a_nd: assert property (p_nd) else $error("flag");
  property p_clr;
    rh && !ps && !x_sample_valid_in ##1 (!x_sample_valid_in) [*2] ##1 lo
      |=> !readdata_out[0];
  endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_hi;
    tr && address_in == 8'h0C && lk |=> readdata_out[7:0] == $past(hv);
  endproperty
  a_hi: assert property (p_hi) else $error("lock");
  property p_h7;
    tr && address_in == 8'h0C && !lk && !x_sample_valid_in
      |=> readdata_out[7:0] == xs[11:4];
  endproperty
  a_h7: assert property (p_h7) else $error("high");
  property p_sc;
    tr && address_in == 8'h70 |=> readdata_out[7:0] == sc;
  endproperty
  a_sc: assert property (p_sc) else $error("scratch");
  c_lk: cover property (tr && address_in == 8'h0C && lk);
  c_sc: cover property (tw && address_in == 8'h70);
  c_cl: cover property (tr && address_in == 8'h0C ##3 lo);
  c_st: cover property (rh && ps);
  c_sd: cover property (rl && sd);
endmodule
bind adr_regs adr_regs_assertions u_chk (.clk_in, .rst_b_in,
  .x_sample_in, .x_sample_valid_in, .address_in, .read_in, .write_in,
  .writedata_in, .readdata_out, .waitrequest_out);

// ==== tb/test_accel_data_readout_regs.sv ====
// self-checking bench for the readout register bank
module test_accel_data_readout_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import adr_pkg::*;
  logic clk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1;
  logic read_in = 1'b0, write_in = 1'b0, x_sample_valid_in = 1'b0;
  logic [11:0] x_sample_in = 12'h000;
  logic [7:0] address_in = 8'h00, q;
  logic [31:0] writedata_in = 32'h0, readdata_out;
  logic [3:0] byteenable_in = 4'h1;
  logic [1:0] response_out, rs;
  logic waitrequest_out, deep_suspend_out, soft_reset_pulse_out, sp;
  int bad_count = 0, n_tests = 0;
  always #4 clk_in = ~clk_in;
  adr_regs dut_u (.clk_in, .rst_b_in, .ce_in, .x_sample_in,
    .x_sample_valid_in, .address_in, .read_in, .write_in, .writedata_in,
    .byteenable_in, .readdata_out, .waitrequest_out, .response_out,
    .deep_suspend_out, .soft_reset_pulse_out);
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address_in <= a;
    writedata_in <= {24'h0, d};
    read_in <= !w;
    write_in <= w;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 20);
    if (waitrequest_out !== 1'b0) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, waitrequest_out, 1'b0);
      print_verdict();
    end
    q = readdata_out[7:0];
    rs = response_out;
    sp = soft_reset_pulse_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic smp(input logic [11:0] v);
    x_sample_in <= v;
    x_sample_valid_in <= 1'b1;
    @(posedge clk_in);
    x_sample_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic t_map;
    acc(1'b1, 8'h00, 8'h11);
    rd(8'h00, IDENT_VALUE);
    chk({6'h0, rs}, 8'h00);
    rd(8'h3C, RST_RANGE);
    rd(8'h70, 8'h00);
    rd(8'h04, 8'h00);
    chk({6'h0, rs}, 8'h02);
  endtask
  task automatic t_x;
    smp(12'hA53);
    rd(8'h08, 8'h31);
    rd(8'h0C, 8'hA5);
    rd(8'h08, 8'h30);
    smp(12'h123);
    rd(8'h08, 8'h31);
    smp(12'h9FE);
    rd(8'h0C, 8'h12);
    rd(8'h08, 8'hE1);
    rd(8'h0C, 8'h9F);
    smp(12'h7C4);
    rd(8'h0C, 8'h7C);
  endtask
  task automatic t_nosh;
    acc(1'b1, 8'h4C, 8'h40);
    rd(8'h4C, 8'h40);
    smp(12'h456);
    rd(8'h08, 8'h61);
    smp(12'h789);
    rd(8'h08, 8'h91);
    rd(8'h08, 8'h90);
    smp(12'hABC);
    rd(8'h0C, 8'hAB);
  endtask
  task automatic t_keep;
    acc(1'b1, 8'h70, 8'hA5);
    acc(1'b1, 8'h3C, 8'h05);
    acc(1'b1, 8'h44, 8'h20);
    chk({7'h0, deep_suspend_out}, 8'h01);
    acc(1'b1, 8'h50, 8'h00);
    chk({7'h0, sp}, 8'h00);
    rd(8'h3C, 8'h05);
    acc(1'b1, 8'h50, SWRST_CODE);
    chk({7'h0, sp}, 8'h01);
    chk({7'h0, soft_reset_pulse_out}, 8'h00);
    rd(8'h3C, RST_RANGE);
    rd(8'h4C, RST_ZERO);
    chk({7'h0, deep_suspend_out}, 8'h00);
    rd(8'h70, 8'hA5);
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    t_map();
    t_x();
    t_nosh();
    t_keep();
    print_verdict();
  end
endmodule
